// ==== hdl/ecs_pkg.sv ====
package ecs_pkg;

  // clock and microsecond tick timing
  localparam int ECS_CLK_PERIOD_NS = 50;      // 20 MHz device clock
  localparam int ECS_TICK_NS       = 1000;    // one microsecond
  localparam int ECS_TICK_CYCLES   = ECS_TICK_NS / ECS_CLK_PERIOD_NS;
  localparam int ECS_CNT_W         = 32;      // counter width

  // register byte offsets
  localparam logic [7:0] ECS_OFS_CTRL   = 8'h00; // source and edge selections
  localparam logic [7:0] ECS_OFS_CMD    = 8'h04; // write-only command
  localparam logic [7:0] ECS_OFS_TARGET = 8'h08; // count_target
  localparam logic [7:0] ECS_OFS_VALUE  = 8'h0C; // live counter value
  localparam logic [7:0] ECS_OFS_CAPT   = 8'h10; // value_captured_on_clear
  localparam logic [7:0] ECS_OFS_STATUS = 8'h14; // state code

  // writable bits of the control word, reset values
  localparam logic [31:0] ECS_CTRL_MASK   = 32'h003F_3F3F;
  localparam logic [31:0] ECS_CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] ECS_TARGET_RST  = 32'h0000_0001;
  localparam int          ECS_CMD_CLR_BIT = 0;
  localparam logic [1:0]  ECS_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  ECS_RESP_SLVERR = 2'h2;

  // event source codes; code 0 means off, or command for the clear selection
  typedef enum logic [3:0] {
    ECS_SRC_OFF       = 4'h0,
    ECS_SRC_ACQ_START = 4'h1,
    ECS_SRC_ACQ_END   = 4'h2,
    ECS_SRC_EXP_START = 4'h3,
    ECS_SRC_EXP_END   = 4'h4,
    ECS_SRC_RO_START  = 4'h5,
    ECS_SRC_RO_END    = 4'h6,
    ECS_SRC_FRAME     = 4'h7,
    ECS_SRC_LINE1     = 4'h8,
    ECS_SRC_LINE2     = 4'h9,
    ECS_SRC_LINE3     = 4'hA,
    ECS_SRC_LINE4     = 4'hB,
    ECS_SRC_ENCODER   = 4'hC,
    ECS_SRC_USEC      = 4'hD,
    ECS_SRC_TIMER1    = 4'hE,
    ECS_SRC_TIMER2    = 4'hF
  } ecs_src_t;

  // line edge qualifier
  typedef enum logic [1:0] {
    ECS_EDGE_RISE = 2'h0,
    ECS_EDGE_FALL = 2'h1,
    ECS_EDGE_ANY  = 2'h2,
    ECS_EDGE_NONE = 2'h3
  } ecs_edge_t;

  // counter state, also read back in the status register
  typedef enum logic [1:0] {
    ECS_ST_IDLE   = 2'h0,
    ECS_ST_WAIT   = 2'h1,
    ECS_ST_ACTIVE = 2'h2,
    ECS_ST_DONE   = 2'h3
  } ecs_state_t;

  // one-cycle event pulses from the acquisition sequencer
  typedef struct packed {
    logic acq_start;
    logic acq_end;
    logic exp_start;
    logic exp_end;
    logic ro_start;
    logic ro_end;
    logic frame_trigger;
  } ecs_seq_ev_t;

  // control word layout
  typedef struct packed {
    logic [9:0] pad3;
    ecs_edge_t  begin_line_edge_select;   // bits 21:20
    ecs_src_t   begin_source_select;      // bits 19:16
    logic [1:0] pad1;
    ecs_edge_t  clear_line_edge_select;   // bits 13:12
    ecs_src_t   clear_source_select;      // bits 11:8
    logic [1:0] pad0;
    ecs_edge_t  count_line_edge_select;   // bits 5:4
    ecs_src_t   count_source_select;      // bits 3:0
  } ecs_ctrl_t;

endpackage : ecs_pkg

// ==== hdl/ecs_line_edge.sv ====
`timescale 1ns/100ps
// two-stage synchroniser plus edge detector per input line
module ecs_line_edge
  import ecs_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] line_in,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  initial begin
    if (N < 1) $error("ecs_line_edge: N must be at least 1");
  end

  logic [N-1:0] meta_ff;  // first stage, read only by sync_ff
  logic [N-1:0] sync_ff;  // second stage, safe to use
  logic [N-1:0] prev_ff;  // previous synchronised level

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_line
      // synchroniser chain and history
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
          prev_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= line_in[gi];
          sync_ff[gi] <= meta_ff[gi];
          prev_ff[gi] <= sync_ff[gi];
        end
      end
      // one pulse per transition
      assign rise[gi] = sync_ff[gi] & ~prev_ff[gi];
      assign fall[gi] = ~sync_ff[gi] & prev_ff[gi];
    end
  endgenerate

endmodule : ecs_line_edge

// ==== hdl/ecs_counter.sv ====
`timescale 1ns/100ps
module ecs_counter
  import ecs_pkg::*;
#(
  parameter int CNT_W  = ECS_CNT_W,       // counter width
  parameter int LINE_N = 4                // input lines
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  // events from the camera logic, same clock
  input  wire ecs_seq_ev_t       seq_ev,
  input  wire logic              encoder_tick,
  input  wire logic              timer_one_done,
  input  wire logic              timer_two_done,
  // asynchronous input lines
  input  wire logic [LINE_N-1:0] line_in,
  output logic                   count_done_event,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  initial begin
    if (CNT_W < 2 || CNT_W > 32) $error("ecs_counter: CNT_W must be 2..32");
    if (LINE_N != 4) $error("ecs_counter: source codes serve exactly four lines");
  end

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // pick edges of each line by qualifier
  function automatic logic [LINE_N-1:0] line_qual(input logic [LINE_N-1:0] r,
                                                  input logic [LINE_N-1:0] f,
                                                  input ecs_edge_t         e);
    case (e)
      ECS_EDGE_RISE: line_qual = r;
      ECS_EDGE_FALL: line_qual = f;
      ECS_EDGE_ANY:  line_qual = r | f;
      default:       line_qual = '0;
    endcase
  endfunction : line_qual

  // event vector indexed by source code; bit 0 left for off or command
  function automatic logic [15:0] ev_vec(input ecs_seq_ev_t       s,
                                         input logic [LINE_N-1:0] ln,
                                         input logic              enc,
                                         input logic              us,
                                         input logic              t1,
                                         input logic              t2);
    ev_vec = {t2, t1, us, enc, ln, s.frame_trigger, s.ro_end, s.ro_start,
              s.exp_end, s.exp_start, s.acq_end, s.acq_start, 1'b0};
  endfunction : ev_vec

  // byte-lane merge for a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      lane_merge[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction : lane_merge

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  logic       rst_meta_ff;        // first stage of reset release
  logic       rst_n;              // synchronised reset

  // async assert, two-stage release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers and state

  ecs_ctrl_t               ctrl_ff;        // selections
  logic      [CNT_W-1:0]   target_ff;      // count_target
  logic      [CNT_W-1:0]   cnt_ff;         // live count
  logic      [CNT_W-1:0]   capt_ff;        // value_captured_on_clear
  logic                    cmd_clear_ff;   // one-cycle clear command
  logic                    done_ff;        // count_done_event pulse
  ecs_state_t              state_ff;
  ecs_state_t              nxt_state;
  logic      [CNT_W-1:0]   nxt_cnt;
  logic      [4:0]         us_div_ff;      // microsecond divider
  logic                    us_tick;        // microsecond_tick enable

  //////////////////////////////////////////////////////////////////////////////
  // input lines and microsecond tick

  logic [LINE_N-1:0] line_rise;
  logic [LINE_N-1:0] line_fall;

  ecs_line_edge #(
    .N       (LINE_N)
  ) u_line_edge (
    .clock   (clock),
    .rst_n   (rst_n),
    .line_in (line_in),
    .rise    (line_rise),
    .fall    (line_fall)
  );

  localparam logic [4:0] US_LAST = 5'(ECS_TICK_CYCLES - 1);

  // divider free-runs so the tick is available whenever selected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      us_div_ff <= '0;
    end else begin
      us_div_ff <= us_tick ? '0 : us_div_ff + 5'h01;
    end
  end
  assign us_tick = (us_div_ff == US_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // source selection

  wire [15:0] count_vec;   // increment candidates
  wire [15:0] clear_vec;   // clear candidates
  wire [15:0] begin_vec;   // start candidates
  wire        inc_hit;
  wire        clr_hit;
  wire        beg_hit;
  wire        begin_off;

  // line edges qualified per selection, sequencer events straight through
  assign count_vec = ev_vec(seq_ev,
                            line_qual(line_rise, line_fall, ctrl_ff.count_line_edge_select),
                            encoder_tick, us_tick, timer_one_done, timer_two_done);
  // encoder and microsecond tick are not clear or start sources
  assign clear_vec = ev_vec(seq_ev,
                            line_qual(line_rise, line_fall, ctrl_ff.clear_line_edge_select),
                            1'b0, 1'b0, timer_one_done, timer_two_done)
                     | {15'h0000, cmd_clear_ff};
  assign begin_vec = ev_vec(seq_ev,
                            line_qual(line_rise, line_fall, ctrl_ff.begin_line_edge_select),
                            1'b0, 1'b0, timer_one_done, timer_two_done);

  // off code selects bit 0, which is always low for counting
  assign inc_hit   = count_vec[ctrl_ff.count_source_select];
  // command only counts when the clear selection is the command code
  assign clr_hit   = clear_vec[ctrl_ff.clear_source_select];
  assign beg_hit   = begin_vec[ctrl_ff.begin_source_select];
  assign begin_off = (ctrl_ff.begin_source_select == ECS_SRC_OFF);

  //////////////////////////////////////////////////////////////////////////////
  // counter state machine

  wire [CNT_W-1:0] cnt_inc = cnt_ff + CNT_W'(1);
  wire             reach   = (cnt_inc >= target_ff);

  // clear wins over start and increment in the same cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (clr_hit) begin
      nxt_cnt   = '0;
      nxt_state = begin_off ? ECS_ST_IDLE : ECS_ST_WAIT;
    end else begin
      case (state_ff)
        ECS_ST_IDLE: begin
          if (!begin_off) nxt_state = ECS_ST_WAIT;
        end
        ECS_ST_WAIT: begin
          if (begin_off) begin
            nxt_state = ECS_ST_IDLE;
          end else if (beg_hit) begin
            nxt_cnt   = '0;
            nxt_state = ECS_ST_ACTIVE;
          end
        end
        ECS_ST_ACTIVE: begin
          if (inc_hit) begin
            nxt_cnt = cnt_inc;
            if (reach) nxt_state = ECS_ST_DONE;
          end
        end
        // holds the final count until the next clear
        ECS_ST_DONE: nxt_state = ECS_ST_DONE;
        default:     nxt_state = ECS_ST_IDLE;
      endcase
    end
  end

  // state, count, capture and done pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ECS_ST_IDLE;
      cnt_ff   <= '0;
      capt_ff  <= '0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (clr_hit) capt_ff <= cnt_ff;
      done_ff  <= (state_ff == ECS_ST_ACTIVE) && (nxt_state == ECS_ST_DONE);
    end
  end

  assign count_done_event = done_ff;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write side

  logic [7:0]  aw_addr_ff;   // captured write address
  logic        aw_got_ff;
  logic [31:0] w_data_ff;    // captured write data
  logic [3:0]  w_strb_ff;
  logic        w_got_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;

  wire do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  wire wr_ctrl  = (aw_addr_ff == ECS_OFS_CTRL);
  wire wr_cmd   = (aw_addr_ff == ECS_OFS_CMD);
  wire wr_tgt   = (aw_addr_ff == ECS_OFS_TARGET);
  // read-only words accept no write and answer an error
  wire wr_ok    = wr_ctrl || wr_cmd || wr_tgt;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // address and data taken in either order, answered once both are in
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr_ff <= '0;
      aw_got_ff  <= 1'b0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
      w_got_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= ECS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
        aw_got_ff  <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_got_ff  <= 1'b1;
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? ECS_RESP_OKAY : ECS_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // software-written registers; command bit is a self-clearing pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff      <= ecs_ctrl_t'(ECS_CTRL_RST);
      target_ff    <= CNT_W'(ECS_TARGET_RST);
      cmd_clear_ff <= 1'b0;
    end else begin
      cmd_clear_ff <= do_write && wr_cmd && w_strb_ff[0] && w_data_ff[ECS_CMD_CLR_BIT];
      if (do_write && wr_ctrl) begin
        ctrl_ff <= ecs_ctrl_t'(lane_merge(32'(ctrl_ff), w_data_ff, w_strb_ff) & ECS_CTRL_MASK);
      end
      if (do_write && wr_tgt) begin
        target_ff <= CNT_W'(lane_merge(32'(target_ff), w_data_ff, w_strb_ff));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read side

  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        rvalid_ff;
  logic [31:0] rd_word;
  logic        rd_ok;

  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};

  // read decode; command word reads as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (rd_addr)
      ECS_OFS_CTRL:   rd_word = 32'(ctrl_ff);
      ECS_OFS_CMD:    rd_word = 32'h0000_0000;
      ECS_OFS_TARGET: rd_word = 32'(target_ff);
      ECS_OFS_VALUE:  rd_word = 32'(cnt_ff);
      ECS_OFS_CAPT:   rd_word = 32'(capt_ff);
      ECS_OFS_STATUS: rd_word = 32'(state_ff);
      default:        rd_ok   = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // one read in flight; data held until taken
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff  <= '0;
      rresp_ff  <= ECS_RESP_OKAY;
      rvalid_ff <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_ok ? ECS_RESP_OKAY : ECS_RESP_SLVERR;
      rvalid_ff <= 1'b1;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule : ecs_counter

// ==== dv/ecs_counter_props.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// bus and event checks
module ecs_counter_chk
  import ecs_pkg::*;
(
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        count_done_event
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  // address and data taken together; read address taken
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // answers on time, then stand
  chk_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // no second transfer while an answer is pending
  chk_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_done_single: assert property (count_done_event |=> !count_done_event)
    else $error("done event longer than one cycle");
endmodule : ecs_counter_chk

bind ecs_counter ecs_counter_chk u_ecs_counter_chk (.*);

// ==== dv/ecs_far_side.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// sequencer, encoder and timer stand-in
module ecs_far_side
  import ecs_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     arst_n,
  input  wire logic     fire,
  input  wire ecs_src_t code,
  output ecs_seq_ev_t   seq_ev,
  output logic          encoder_tick,
  output logic          timer_one_done,
  output logic          timer_two_done
);
  // one pulse per request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seq_ev         <= '0;
      encoder_tick   <= 1'b0;
      timer_one_done <= 1'b0;
      timer_two_done <= 1'b0;
    end else begin
      encoder_tick   <= fire && (code == ECS_SRC_ENCODER);
      timer_one_done <= fire && (code == ECS_SRC_TIMER1);
      timer_two_done <= fire && (code == ECS_SRC_TIMER2);
      seq_ev         <= (fire && code inside {[ECS_SRC_ACQ_START:ECS_SRC_FRAME]}) ?
                        ecs_seq_ev_t'(7'h40 >> (code - ECS_SRC_ACQ_START)) : '0;
    end
  end
endmodule : ecs_far_side

// ==== dv/ecs_counter_tb.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module ecs_counter_tb
  import ecs_pkg::*;
;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        fire = 1'b0;
  ecs_src_t    fire_code = ECS_SRC_OFF;
  logic [3:0]  line_lvl = 4'h0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  ecs_seq_ev_t seq_ev;
  logic        enc, t1, t2, done, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          err_total = 0;
  int          comparisons = 0;
  int          done_cnt = 0;

  initial forever #25 clock = ~clock;
  always @(posedge clock) if (done === 1'b1) done_cnt++;

  ecs_far_side u_ecs_far_side (.clock, .arst_n, .fire, .code(fire_code),
    .seq_ev(seq_ev), .encoder_tick(enc), .timer_one_done(t1), .timer_two_done(t2));
  // byte strobes tied on: whole words only
  ecs_counter u_ecs_counter (.clock, .arst_n, .seq_ev, .encoder_tick(enc),
    .timer_one_done(t1), .timer_two_done(t2), .line_in(line_lvl), .count_done_event(done),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic lapse();
    err_total++;
    $display("Error %0t wait ran out", $time);
    tally_and_finish();
  endtask : lapse
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t response %h expected %h", $time, got, exp);
    end
  endtask : chk_resp
  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    comparisons++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      err_total++;
      $display("Error %0t word %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : chk_in
  ////////////////////////////////////////////////////////////////////////
  // write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   i;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && (aw || w); i++) begin
      @(posedge clock);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    for (i = 0; i < 50 && bvalid !== 1'b1; i++) @(posedge clock);
    if (i == 50) lapse();
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1 && ++i < 50);
    arvalid <= 1'b0;
    for (i = 0; i < 50 && rvalid !== 1'b1; i++) @(posedge clock);
    if (i == 50) lapse();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk_word(d, e);
  endtask : rd_chk
  // one occurrence of a far-side event
  task automatic pulse(input ecs_src_t c);
    @(posedge clock);
    fire <= 1'b1;
    fire_code <= c;
    @(posedge clock);
    fire <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : pulse
  // line level held long enough to pass the synchroniser
  task automatic line_set(input int ln, input logic v);
    @(posedge clock);
    line_lvl[ln] <= v;
    repeat (5) @(posedge clock);
  endtask : line_set
  function automatic logic [31:0] exp_line(input int k, input ecs_edge_t e);
    return (e == ECS_EDGE_ANY) ? 32'(2 * k) : 32'(k);
  endfunction : exp_line
  // start source must differ from the source under test
  function automatic ecs_src_t begin_for(input ecs_src_t c);
    return (c == ECS_SRC_ACQ_START) ? ECS_SRC_ACQ_END : ECS_SRC_ACQ_START;
  endfunction : begin_for
  function automatic logic [31:0] mk_ctrl(input ecs_src_t cs, input ecs_edge_t ce, input ecs_src_t ks,
                                          input ecs_edge_t ke, input ecs_src_t bs);
    return {12'h000, bs, 2'b00, ke, ks, 2'b00, ce, cs};
  endfunction : mk_ctrl
  // command clear, then setup, then start
  task automatic arm(input ecs_src_t cs, input ecs_edge_t ce, input ecs_src_t ks, input ecs_edge_t ke,
                     input ecs_src_t bs);
    logic [1:0] r;
    axi_write(ECS_OFS_CTRL, mk_ctrl(cs, ce, ECS_SRC_OFF, ke, bs), r);
    axi_write(ECS_OFS_CMD, 32'h0000_0001, r);
    axi_write(ECS_OFS_CTRL, mk_ctrl(cs, ce, ks, ke, bs), r);
    pulse(bs);
  endtask : arm

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d, prev;
    logic [1:0]  r;
    int          n, k;
    ecs_src_t    c;
    void'($urandom(24));
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk(ECS_OFS_CTRL, ECS_CTRL_RST);
    rd_chk(ECS_OFS_TARGET, ECS_TARGET_RST);
    axi_read(8'h18, d, r);
    chk_resp(r, ECS_RESP_SLVERR);
    axi_write(ECS_OFS_VALUE, 32'h0000_0005, r);
    chk_resp(r, ECS_RESP_SLVERR);
    axi_write(ECS_OFS_TARGET, 32'h0000_FFFF, r);
    chk_resp(r, ECS_RESP_OKAY);
    $display("test registers done");
    prev = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      if (i inside {[8:11], 13}) continue;
      c = ecs_src_t'(i);
      n = $urandom_range(6, 1);
      arm(c, ECS_EDGE_RISE, ECS_SRC_OFF, ECS_EDGE_RISE, begin_for(c));
      rd_chk(ECS_OFS_CAPT, prev);
      repeat (n) pulse(c);
      pulse((c == ECS_SRC_ENCODER) ? ECS_SRC_TIMER1 : ECS_SRC_ENCODER);
      prev = (c == ECS_SRC_OFF) ? 32'h0000_0000 : 32'(n);
      rd_chk(ECS_OFS_VALUE, prev);
    end
    $display("test event sources done");
    for (int ln = 0; ln < 4; ln++) begin
      for (int e = 0; e < 3; e++) begin
        k = $urandom_range(3, 1);
        arm(ecs_src_t'(8 + ln), ecs_edge_t'(e), ECS_SRC_OFF, ECS_EDGE_RISE, ECS_SRC_ACQ_START);
        repeat (k) begin
          line_set(ln, 1'b1);
          line_set(ln, 1'b0);
        end
        rd_chk(ECS_OFS_VALUE, exp_line(k, ecs_edge_t'(e)));
      end
    end
    $display("test line sources done");
    arm(ECS_SRC_USEC, ECS_EDGE_RISE, ECS_SRC_OFF, ECS_EDGE_RISE, ECS_SRC_ACQ_START);
    repeat (200) @(posedge clock);
    axi_read(ECS_OFS_VALUE, d, r);
    chk_in(d, 32'(200 / ECS_TICK_CYCLES - 1), 32'(200 / ECS_TICK_CYCLES + 1));
    $display("test microsecond done");
    for (int i = 1; i < 12; i++) begin
      c = ecs_src_t'(i);
      n = $urandom_range(5, 1);
      arm(ECS_SRC_ENCODER, ECS_EDGE_RISE, c, ecs_edge_t'(i % 3), begin_for(c));
      repeat (n) pulse(ECS_SRC_ENCODER);
      axi_write(ECS_OFS_CMD, 32'h0000_0001, r);
      rd_chk(ECS_OFS_VALUE, 32'(n));
      if (i < 8) begin
        pulse(c);
      end else begin
        line_set(i - 8, 1'b1);
        line_set(i - 8, 1'b0);
      end
      // either-edge lines clear again on the fall, capturing zero
      rd_chk(ECS_OFS_CAPT, (i == 8 || i == 11) ? 32'h0000_0000 : 32'(n));
      pulse(ECS_SRC_ENCODER);
      rd_chk(ECS_OFS_VALUE, 32'h0000_0000);
    end
    $display("test clear sources done");
    axi_write(ECS_OFS_TARGET, 32'h0000_0003, r);
    arm(ECS_SRC_ENCODER, ECS_EDGE_RISE, ECS_SRC_OFF, ECS_EDGE_RISE, ECS_SRC_ACQ_START);
    k = done_cnt;
    repeat (2) pulse(ECS_SRC_ENCODER);
    chk_word(32'(done_cnt - k), 32'h0000_0000);
    pulse(ECS_SRC_ENCODER);
    repeat (3) @(posedge clock);
    chk_word(32'(done_cnt - k), 32'h0000_0001);
    $display("test done event done");
    tally_and_finish();
  end
endmodule : ecs_counter_tb
